/* File: rbt_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module rbt_far_end (
    // device pins
    input  wire rbt_pkg::rbt_pins_t a_pins,
    input  wire rbt_pkg::rbt_pins_t b_pins,
    // far-side drivers
    input  wire rbt_pkg::rbt_byte_t a_drv,
    input  wire rbt_pkg::rbt_byte_t b_drv,
    // resolved bus levels
    output rbt_pkg::rbt_byte_t      a_bus,
    output rbt_pkg::rbt_byte_t      b_bus
);
    // released bits show the far side's value, so a stale output never passes
    assign a_bus = (a_pins.oe & a_pins.o) | (~a_pins.oe & a_drv);
    assign b_bus = (b_pins.oe & b_pins.o) | (~b_pins.oe & b_drv);
endmodule
`default_nettype wire

/* File: rbt_pkg.sv */
`default_nettype none
package rbt_pkg;
    localparam int unsigned DATA_W  = 8;
    localparam int unsigned BUF_DEP = 2;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic               FLAG_RST = 1'b0;

    typedef logic [DATA_W-1:0] rbt_byte_t;

    // one direction's control pins
    typedef struct packed {
        logic load_clock;
        logic capture_enable_n;
        logic drive_enable_n;
    } rbt_dir_ctl_t;

    // one side's three-state pin group
    typedef struct packed {
        rbt_byte_t o;
        rbt_byte_t oe;
    } rbt_pins_t;
endpackage
`default_nettype wire

/* File: rbt_transceiver.sv */
// Operation
// R1 - A-to-B register loads on edge while enable low (here also only while ab_in_ready is high)
// R2 - each A-to-B load sets the loaded flag
// R3 - stored A-to-B data drives B when enabled
// R4 - disabled side pins float, act as inputs
// R5 - B-to-A direction mirrors A-to-B with own controls
// R6 - two independent back-to-back 8-bit registers
// R7 - inverting variant drives complement of stored bits
// R8 - each direction has its own clock, enables
// R9 - no reset pin; contents undefined until loaded (here srst loads rbt_pkg::DATA_RST)
`timescale 1ns/1ps
`default_nettype none
module rbt_transceiver #(
    parameter bit INVERT = 1'b0
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               srst,
    // per-direction controls
    input  wire rbt_pkg::rbt_dir_ctl_t ab_ctl,
    input  wire rbt_pkg::rbt_dir_ctl_t ba_ctl,
    // bus pins, split three ways
    input  wire rbt_pkg::rbt_byte_t a_i,
    input  wire rbt_pkg::rbt_byte_t b_i,
    output rbt_pkg::rbt_pins_t      a_pins,
    output rbt_pkg::rbt_pins_t      b_pins,
    // status
    output logic                    a_to_b_loaded_flag,
    // buffered A-to-B word stream
    output logic                    ab_out_valid,
    output rbt_pkg::rbt_byte_t      ab_out_data,
    input  wire logic               ab_out_ready,
    output logic                    ab_in_ready
);
    logic ab_clk_q;
    logic ba_clk_q;
    logic ab_load;
    logic ba_load;
    rbt_pkg::rbt_byte_t ab_reg_q;
    rbt_pkg::rbt_byte_t ba_reg_q;
    rbt_pkg::rbt_byte_t skid_dat_q;
    rbt_pkg::rbt_byte_t skid_dat_d;
    rbt_pkg::rbt_byte_t out_dat_d;
    logic               skid_vld_q;
    logic               skid_vld_d;
    logic               out_vld_d;
    logic               slot_free;
    logic               push;
    logic               pop;

    // load clocks are sampled pins; a rising edge is a load opportunity
    always_ff @(posedge clk) begin
        ab_clk_q <= srst ? 1'b0 : ab_ctl.load_clock;
        ba_clk_q <= srst ? 1'b0 : ba_ctl.load_clock;
    end

    // stalling on a full buffer holds the register rather than losing a word
    assign ab_load = ab_ctl.load_clock & ~ab_clk_q & ~ab_ctl.capture_enable_n & ab_in_ready; // R1 R8
    assign ba_load = ba_ctl.load_clock & ~ba_clk_q & ~ba_ctl.capture_enable_n; // R5 R8

    // srst is a simulation convenience; the part itself has none
    always_ff @(posedge clk) begin
        if (srst) begin
            ab_reg_q <= rbt_pkg::DATA_RST; // R9
        end else if (ab_load) begin
            ab_reg_q <= a_i; // R1 R6
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ba_reg_q <= rbt_pkg::DATA_RST; // R9
        end else if (ba_load) begin
            ba_reg_q <= b_i; // R5 R6
        end
    end

    // flag is never cleared by any documented event
    always_ff @(posedge clk) begin
        if (srst) begin
            a_to_b_loaded_flag <= rbt_pkg::FLAG_RST;
        end else if (ab_load) begin
            a_to_b_loaded_flag <= 1'b1; // R2
        end
    end

    // pin drivers, registered, with load data bypassed so outputs change on the same edge as the register
    always_ff @(posedge clk) begin
        if (srst) begin
            b_pins <= '0;
            a_pins <= '0;
        end else begin
            b_pins.o  <= (ab_load ? a_i : ab_reg_q) ^ {rbt_pkg::DATA_W{INVERT}}; // R3 R7
            b_pins.oe <= {rbt_pkg::DATA_W{~ab_ctl.drive_enable_n}}; // R3 R4
            a_pins.o  <= (ba_load ? b_i : ba_reg_q) ^ {rbt_pkg::DATA_W{INVERT}}; // R5 R7
            a_pins.oe <= {rbt_pkg::DATA_W{~ba_ctl.drive_enable_n}}; // R4 R5
        end
    end

    // two-entry buffer: an output slot with a skid slot behind it
    // ready drops only while the skid slot holds a word, so a stall loses nothing
    assign push      = ab_load;
    assign pop       = ab_out_valid & ab_out_ready;
    assign slot_free = pop | ~ab_out_valid;

    always_comb begin
        skid_vld_d = skid_vld_q;
        skid_dat_d = skid_dat_q;
        out_vld_d  = ab_out_valid;
        out_dat_d  = ab_out_data;
        if (slot_free) begin
            if (skid_vld_q) begin
                out_vld_d  = 1'b1;
                out_dat_d  = skid_dat_q;
                skid_vld_d = push;
                if (push) begin
                    skid_dat_d = a_i;
                end
            end else begin
                out_vld_d = push;
                if (push) begin
                    out_dat_d = a_i;
                end
            end
        end else if (push) begin
            skid_vld_d = 1'b1;
            skid_dat_d = a_i;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            skid_vld_q   <= 1'b0;
            skid_dat_q   <= rbt_pkg::DATA_RST;
            ab_out_valid <= 1'b0;
            ab_out_data  <= rbt_pkg::DATA_RST;
            ab_in_ready  <= 1'b1;
        end else begin
            skid_vld_q   <= skid_vld_d;
            skid_dat_q   <= skid_dat_d;
            ab_out_valid <= out_vld_d;
            ab_out_data  <= out_dat_d;
            ab_in_ready  <= ~skid_vld_d; // R1
        end
    end

    sequence ab_edge_s;
        $rose(ab_ctl.load_clock) && !ab_ctl.capture_enable_n && ab_in_ready;
    endsequence

    sequence ba_edge_s;
        $rose(ba_ctl.load_clock) && !ba_ctl.capture_enable_n;
    endsequence

    sequence stall_s;
        ab_out_valid && !ab_out_ready;
    endsequence

    ab_load_data_a: assert property (@(posedge clk) disable iff (srst) // R1
        ab_edge_s |=> ab_reg_q == $past(a_i))
        else $error("a-to-b register missed a load");
    ab_hold_a: assert property (@(posedge clk) disable iff (srst) // R1
        ab_ctl.capture_enable_n |=> $stable(ab_reg_q))
        else $error("a-to-b register changed while disabled");
    flag_set_a: assert property (@(posedge clk) disable iff (srst) // R2
        ab_edge_s |=> a_to_b_loaded_flag)
        else $error("flag not set on load");
    b_drive_a: assert property (@(posedge clk) disable iff (srst) // R3
        !ab_ctl.drive_enable_n ##1 !ab_ctl.drive_enable_n |=> b_pins.oe == 8'hFF)
        else $error("b pins not driven");
    b_float_a: assert property (@(posedge clk) disable iff (srst) // R4
        ab_ctl.drive_enable_n |=> b_pins.oe == 8'h00)
        else $error("b pins driven while disabled");
    ba_load_data_a: assert property (@(posedge clk) disable iff (srst) // R5
        ba_edge_s |=> ba_reg_q == $past(b_i))
        else $error("b-to-a register missed a load");
    ba_indep_a: assert property (@(posedge clk) disable iff (srst) // R6
        ab_load && !ba_load |=> $stable(ba_reg_q))
        else $error("registers not independent");
    polarity_a: assert property (@(posedge clk) disable iff (srst) // R7
        ##1 !$past(ab_load) |-> b_pins.o == ($past(ab_reg_q) ^ {8{INVERT}}))
        else $error("b output polarity wrong");

    ba_hold_a: assert property (@(posedge clk) disable iff (srst) // R5
        ba_ctl.capture_enable_n |=> $stable(ba_reg_q))
        else $error("b-to-a register changed while disabled");
    a_drive_a: assert property (@(posedge clk) disable iff (srst) // R5
        !ba_ctl.drive_enable_n |=> a_pins.oe == 8'hFF)
        else $error("a pins not driven");

    a_float_a: assert property (@(posedge clk) disable iff (srst) // R4
        ba_ctl.drive_enable_n |=> a_pins.oe == 8'h00)
        else $error("a pins driven while disabled");
    flag_sticky_a: assert property (@(posedge clk) disable iff (srst) // R2
        a_to_b_loaded_flag |=> a_to_b_loaded_flag)
        else $error("flag cleared without reset");

    flag_quiet_a: assert property (@(posedge clk) disable iff (srst) // R2
        !a_to_b_loaded_flag && !ab_load |=> !a_to_b_loaded_flag)
        else $error("flag set without a load");
    ab_indep_a: assert property (@(posedge clk) disable iff (srst) // R6
        ba_load && !ab_load |=> $stable(ab_reg_q))
        else $error("a-to-b register disturbed");

    a_polarity_a: assert property (@(posedge clk) disable iff (srst) // R7
        ##1 !$past(ba_load) |-> a_pins.o == ($past(ba_reg_q) ^ {8{INVERT}}))
        else $error("a output polarity wrong");
    b_bypass_a: assert property (@(posedge clk) disable iff (srst) // R3
        ab_load |=> b_pins.o == ($past(a_i) ^ {8{INVERT}}))
        else $error("b pins missed new data");

    a_bypass_a: assert property (@(posedge clk) disable iff (srst) // R5
        ba_load |=> a_pins.o == ($past(b_i) ^ {8{INVERT}}))
        else $error("a pins missed new data");
    stall_hold_a: assert property (@(posedge clk) disable iff (srst) // R1
        stall_s |=> ab_out_valid && $stable(ab_out_data))
        else $error("stalled word lost or changed");

    push_valid_a: assert property (@(posedge clk) disable iff (srst) // R1
        ab_load |=> ab_out_valid)
        else $error("loaded word not offered");
    full_refuse_a: assert property (@(posedge clk) disable iff (srst) // R1
        !ab_in_ready |=> $stable(ab_reg_q))
        else $error("register loaded while buffer full");
endmodule
`default_nettype wire

/* File: tb_registered_bus_transceiver.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_registered_bus_transceiver;
    logic                  clk, srst, rdy, flag, vld, in_rdy;
    rbt_pkg::rbt_dir_ctl_t ab, ba;
    rbt_pkg::rbt_byte_t    a_drv, b_drv, a_bus, b_bus, dat;
    rbt_pkg::rbt_pins_t    a_p, b_p, b_pi;
    int                    err_total = 0;
    int                    n_checks = 0;
    rbt_transceiver #(.INVERT(1'b0)) u_dut (.clk(clk), .srst(srst), .ab_ctl(ab), .ba_ctl(ba),
        .a_i(a_bus), .b_i(b_bus), .a_pins(a_p), .b_pins(b_p), .a_to_b_loaded_flag(flag),
        .ab_out_valid(vld), .ab_out_data(dat), .ab_out_ready(rdy), .ab_in_ready(in_rdy));
    // inverting variant shares every input; only its b pins are judged
    rbt_transceiver #(.INVERT(1'b1)) u_dut_inv (.clk(clk), .srst(srst), .ab_ctl(ab), .ba_ctl(ba),
        .a_i(a_bus), .b_i(b_bus), .a_pins(), .b_pins(b_pi), .a_to_b_loaded_flag(),
        .ab_out_valid(), .ab_out_data(), .ab_out_ready(rdy), .ab_in_ready());
    rbt_far_end u_far (.a_pins(a_p), .b_pins(b_p), .a_drv(a_drv), .b_drv(b_drv), .a_bus(a_bus), .b_bus(b_bus));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    // load_clock needs a low cycle between rising edges
    task automatic pulse(input bit to_b, input logic [7:0] d);
        if (to_b) begin a_drv = d; ab.load_clock = 1'b1; end
        else begin b_drv = d; ba.load_clock = 1'b1; end
        step(1);
        ab.load_clock = 1'b0;
        ba.load_clock = 1'b0;
        step(1);
    endtask
    task automatic pop(input logic [7:0] e);
        for (int i = 0; i < 8 && vld !== 1'b1; i++) step(1);
        if (vld !== 1'b1) begin
            chk(vld, 1'b1);
            end_of_test();
        end
        chk(vld, 1'b1);
        chk(dat, e);
        step(1);
    endtask
    task automatic t_load_hold();
        chk(flag, 1'b0);
        pulse(1, 8'h5A);
        chk({flag, b_bus}, 9'h15A);
        chk(b_p.oe, 8'hFF);
        chk(b_pi.o, 8'hA5);
        ab.capture_enable_n = 1'b1;
        pulse(1, 8'hC3);
        chk(b_p.o, 8'h5A);
        ab.drive_enable_n = 1'b1;
        step(2);
        chk(b_p.oe, 8'h00);
    endtask
    task automatic t_back_dir();
        ba.drive_enable_n = 1'b0;
        pulse(0, 8'h96);
        chk({a_p.oe, a_bus}, 16'hFF96);
        chk(b_p.o, 8'h5A);
        ba.drive_enable_n = 1'b1;
        step(2);
        chk(a_p.oe, 8'h00);
    endtask
    // stalled receiver: two words fit, a third is refused and nothing is lost
    task automatic t_buffer();
        rdy = 1'b0;
        ab.capture_enable_n = 1'b0;
        pulse(1, 8'h11);
        pulse(1, 8'h22);
        chk(in_rdy, 1'b0);
        pulse(1, 8'h33);
        chk(b_p.o, 8'h22);
        rdy = 1'b1;
        pop(8'h11);
        pop(8'h22);
        step(1);
        chk(vld, 1'b0);
        chk(in_rdy, 1'b1);
    endtask
    // mid-run reset clears the flag again
    task automatic t_rereset();
        srst = 1'b1;
        step(2);
        srst = 1'b0;
        step(1);
        chk({flag, vld}, 2'b00);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        srst = 1'b1;
        rdy = 1'b1;
        a_drv = 8'h00;
        b_drv = 8'hFF;
        ab = '0;
        ba = '0;
        ba.drive_enable_n = 1'b1;
        step(16);
        srst = 1'b0;
        step(1);
        t_load_hold();
        t_back_dir();
        t_buffer();
        t_rereset();
        end_of_test();
    end
endmodule
`default_nettype wire
